// >>> pclt_pkg.sv
`default_nettype none
package pclt_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PERIOD_US = 1000;
  localparam int unsigned ZERO_US = 500;
  localparam int unsigned ONE_US = 750;
  localparam int unsigned START_US = 900;
  localparam int unsigned GAP_MS = 22;
  localparam int unsigned TOL_US = 50;
  localparam int unsigned RX_START_US = (START_US + ONE_US) / 2;
  localparam int unsigned RX_ONE_US = (ONE_US + ZERO_US) / 2;
  localparam int unsigned PERIOD_CYC = PERIOD_US * CLK_MHZ;
  localparam int unsigned ZERO_CYC = ZERO_US * CLK_MHZ;
  localparam int unsigned ONE_CYC = ONE_US * CLK_MHZ;
  localparam int unsigned START_CYC = START_US * CLK_MHZ;
  localparam int unsigned GAP_CYC = GAP_MS * 1000 * CLK_MHZ;
  localparam int unsigned TOL_CYC = TOL_US * CLK_MHZ;
  localparam int unsigned RX_START_CYC = RX_START_US * CLK_MHZ;
  localparam int unsigned RX_ONE_CYC = RX_ONE_US * CLK_MHZ;
  localparam int unsigned CW = 24;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [3:0] FRAME_PULSES = 4'hA;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [1:0] SIG_POWER = 2'h1;
  localparam logic [1:0] SIG_CURRENT = 2'h2;
  localparam logic MODE_POWER = 1'h0;
  localparam logic MODE_CURRENT = 1'h1;

  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_TELEM = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'hC;
  localparam int unsigned CMD_MODE_BIT = 8;
  localparam int unsigned TELEM_NEW_BIT = 8;
  localparam int unsigned FIFO_W = 9;
  localparam int unsigned FIFO_D = 16;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DEC_IDLE, DEC_HIGH, DEC_LOW} pclt_dec_t;
  typedef enum logic {ENC_IDLE, ENC_SEND} pclt_enc_t;
  typedef enum logic [1:0] {SND_IDLE, SND_PULSE, SND_GAP} pclt_snd_t;
endpackage : pclt_pkg
`default_nettype wire

// >>> pclt_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pclt_link_if;
  // Limit-setting line, driven by the controller
  logic lim_oe;
  logic lim_out;
  // Level seen on the line; undriven reads low
  logic lim_level;
  // Event indication line, driven by the device
  logic evt;

  assign lim_level = lim_oe & lim_out;

  modport dev (
    input lim_oe,
    input lim_level,
    output evt
  );
  modport ctl (
    output lim_oe,
    output lim_out,
    input evt
  );
endinterface : pclt_link_if
`default_nettype wire

// >>> pclt_device.sv
// Function
// - report opens with 900us start pulse
// - data bit 500us zero, 750us one
// - eight data pulses carry input power
// - controller pulses 1000us period, 500/750us high
// - two signature pulses then eight data
// - 50% decodes zero, 75% decodes one
// - signature 50 then 75 selects power
// - signature 75 then 50 selects current
// - controller idles 22ms between frames
// - mode changes only while loop idle
// - decoded frame replaces stored level
// - latest level drives limit loop
// - power up uses classification level
// - floating power mode, tied low current
// - no frames on a floating line keeps power mode
`timescale 1ns/1ns
`default_nettype none
module pclt_device #(
  parameter int unsigned PER_CYC = pclt_pkg::PERIOD_CYC,
  parameter int unsigned ZERO_CYC = pclt_pkg::ZERO_CYC,
  parameter int unsigned ONE_CYC = pclt_pkg::ONE_CYC,
  parameter int unsigned START_CYC = pclt_pkg::START_CYC,
  parameter int unsigned GAP_CYC = pclt_pkg::GAP_CYC,
  parameter int unsigned TOL_CYC = pclt_pkg::TOL_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Link
  pclt_link_if.dev link,
  // Limit loop side
  input wire logic [7:0] class_level,
  input wire logic loop_active,
  output logic [7:0] limit_level,
  output logic limit_mode,
  output logic frame_ok,
  output logic frame_err,
  // Telemetry side
  input wire logic [7:0] power_level,
  input wire logic report_go,
  output logic report_busy
);
  localparam int unsigned CW = pclt_pkg::CW;

  typedef struct packed {
    pclt_pkg::pclt_dec_t dst;
    logic [CW-1:0] cnt;
    logic prev;
    logic [3:0] npulse;
    logic [9:0] bits;
    logic from_frame;
    logic [7:0] level;
    logic mode;
    logic pend;
    logic pmode;
    logic strap;
    logic ok;
    logic err;
    pclt_pkg::pclt_enc_t est;
    logic [CW-1:0] ecnt;
    logic [3:0] eidx;
    logic [7:0] edata;
    logic evt;
  } pclt_dev_st_t;

  pclt_dev_st_t r_reg;
  pclt_dev_st_t r_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic pclt_near(input logic [CW-1:0] v, input int unsigned c);
    pclt_near = (v >= CW'(c - TOL_CYC)) && (v <= CW'(c + TOL_CYC));
  endfunction : pclt_near

  function automatic logic [CW-1:0] pclt_enc_high(input logic [3:0] idx, input logic b);
    if (idx == 4'h0) begin
      pclt_enc_high = CW'(START_CYC);
    end else if (b) begin
      pclt_enc_high = CW'(ONE_CYC);
    end else begin
      pclt_enc_high = CW'(ZERO_CYC);
    end
  endfunction : pclt_enc_high

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic lvl;
    logic rise;
    logic fall;
    logic bitv;
    logic [9:0] sh;
    lvl = link.lim_level;
    rise = lvl & ~r_reg.prev;
    fall = ~lvl & r_reg.prev;
    bitv = 1'h0;
    sh = r_reg.bits;
    r_next = r_reg;
    r_next.prev = lvl;
    r_next.ok = 1'h0;
    r_next.err = 1'h0;
    if (r_reg.cnt != {CW{1'h1}}) begin
      r_next.cnt = r_reg.cnt + CW'(1);
    end
    if (!r_reg.from_frame) begin
      r_next.level = class_level;
    end
    unique case (r_reg.dst)
      pclt_pkg::DEC_IDLE: begin
        if (rise) begin
          r_next.dst = pclt_pkg::DEC_HIGH;
          r_next.cnt = '0;
          r_next.npulse = 4'h0;
        end else if (r_reg.cnt >= CW'(GAP_CYC)) begin
          if (link.lim_oe && !r_reg.strap) begin
            r_next.strap = 1'h1;
            r_next.pend = 1'h1;
            r_next.pmode = pclt_pkg::MODE_CURRENT;
          end else if (!link.lim_oe && r_reg.strap) begin
            r_next.strap = 1'h0;
            r_next.pend = 1'h1;
            r_next.pmode = pclt_pkg::MODE_POWER;
          end
        end
      end
      pclt_pkg::DEC_HIGH: begin
        if (fall) begin
          bitv = pclt_near(r_reg.cnt, ONE_CYC);
          // first pulse lands in top bit
          sh = {r_reg.bits[8:0], bitv};
          r_next.bits = sh;
          r_next.npulse = r_reg.npulse + 4'h1;
          if (!bitv && !pclt_near(r_reg.cnt, ZERO_CYC)) begin
            r_next.err = 1'h1;
            r_next.dst = pclt_pkg::DEC_IDLE;
            r_next.cnt = '0;
          end else if (r_next.npulse == pclt_pkg::FRAME_PULSES) begin
            r_next.dst = pclt_pkg::DEC_IDLE;
            r_next.cnt = '0;
            if (sh[9:8] == pclt_pkg::SIG_POWER || sh[9:8] == pclt_pkg::SIG_CURRENT) begin
              r_next.level = sh[7:0];
              r_next.from_frame = 1'h1;
              r_next.ok = 1'h1;
              r_next.pend = 1'h1;
              r_next.strap = 1'h0;
              r_next.pmode = (sh[9:8] == pclt_pkg::SIG_CURRENT);
            end else begin
              r_next.err = 1'h1;
            end
          end else begin
            r_next.dst = pclt_pkg::DEC_LOW;
          end
        end else if (r_reg.cnt > CW'(ONE_CYC + TOL_CYC)) begin
          r_next.err = 1'h1;
          r_next.dst = pclt_pkg::DEC_IDLE;
          r_next.cnt = '0;
        end
      end
      pclt_pkg::DEC_LOW: begin
        if (rise) begin
          r_next.cnt = '0;
          r_next.dst = pclt_pkg::DEC_HIGH;
          if (!pclt_near(r_reg.cnt, PER_CYC)) begin
            r_next.err = 1'h1;
            r_next.npulse = 4'h0;
          end
        end else if (r_reg.cnt > CW'(PER_CYC + TOL_CYC)) begin
          r_next.err = 1'h1;
          r_next.dst = pclt_pkg::DEC_IDLE;
          r_next.cnt = '0;
        end
      end
      default: begin
        r_next.dst = pclt_pkg::DEC_IDLE;
      end
    endcase
    // mode switch waits for idle loop
    if (r_next.pend && !loop_active) begin
      r_next.mode = r_next.pmode;
      r_next.pend = 1'h0;
    end

    // --------------------------------------------------------------
    // Telemetry encoder
    // --------------------------------------------------------------
    unique case (r_reg.est)
      pclt_pkg::ENC_IDLE: begin
        if (report_go) begin
          r_next.est = pclt_pkg::ENC_SEND;
          r_next.edata = power_level;
          r_next.eidx = 4'h0;
          r_next.ecnt = '0;
        end
      end
      pclt_pkg::ENC_SEND: begin
        r_next.ecnt = r_reg.ecnt + CW'(1);
        if (r_reg.ecnt == CW'(PER_CYC - 1)) begin
          r_next.ecnt = '0;
          if (r_reg.eidx == pclt_pkg::DATA_BITS) begin
            r_next.est = pclt_pkg::ENC_IDLE;
          end else begin
            r_next.eidx = r_reg.eidx + 4'h1;
            if (r_reg.eidx != 4'h0) begin
              r_next.edata = {r_reg.edata[6:0], 1'h0};
            end
          end
        end
      end
      default: begin
        r_next.est = pclt_pkg::ENC_IDLE;
      end
    endcase
    r_next.evt = (r_next.est == pclt_pkg::ENC_SEND) &&
                 (r_next.ecnt < pclt_enc_high(r_next.eidx, r_next.edata[7]));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign limit_level = r_reg.level;
  assign limit_mode = r_reg.mode;
  assign frame_ok = r_reg.ok;
  assign frame_err = r_reg.err;
  assign report_busy = (r_reg.est == pclt_pkg::ENC_SEND);
  assign link.evt = r_reg.evt;
endmodule : pclt_device
`default_nettype wire

// >>> pclt_controller.sv
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module pclt_fifo #(
  parameter int unsigned W = pclt_pkg::FIFO_W,
  parameter int unsigned D = pclt_pkg::FIFO_D
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } pclt_fifo_st_t;

  pclt_fifo_st_t f_reg;
  pclt_fifo_st_t f_next;

  always_comb begin
    logic push;
    logic pop;
    push = in_valid && (f_reg.cnt != (AW + 1)'(D));
    pop = out_ready && (f_reg.cnt != '0);
    f_next = f_reg;
    if (push) begin
      f_next.mem[f_reg.wp] = in_data;
      f_next.wp = f_reg.wp + AW'(1);
    end
    if (pop) begin
      f_next.rp = f_reg.rp + AW'(1);
    end
    f_next.cnt = f_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  assign in_ready = (f_reg.cnt != (AW + 1)'(D));
  assign out_valid = (f_reg.cnt != '0);
  assign out_data = f_reg.mem[f_reg.rp];
endmodule : pclt_fifo

module pclt_controller #(
  parameter int unsigned PER_CYC = pclt_pkg::PERIOD_CYC,
  parameter int unsigned ZERO_CYC = pclt_pkg::ZERO_CYC,
  parameter int unsigned ONE_CYC = pclt_pkg::ONE_CYC,
  parameter int unsigned GAP_CYC = pclt_pkg::GAP_CYC,
  parameter int unsigned RX_START_CYC = pclt_pkg::RX_START_CYC,
  parameter int unsigned RX_ONE_CYC = pclt_pkg::RX_ONE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Link
  pclt_link_if.ctl link,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int unsigned CW = pclt_pkg::CW;
  localparam int unsigned FW = pclt_pkg::FIFO_W;

  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    pclt_pkg::pclt_snd_t sst;
    logic [CW-1:0] scnt;
    logic [3:0] sidx;
    logic [9:0] sbits;
    logic oe;
    logic out;
    logic strap;
    logic [7:0] sent;
    logic prev;
    logic [CW-1:0] rcnt;
    logic [3:0] ridx;
    logic [7:0] rshift;
    logic [7:0] tele;
    logic tnew;
  } pclt_ctl_st_t;

  pclt_ctl_st_t c_reg;
  pclt_ctl_st_t c_next;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FW-1:0] fifo_out_data;
  logic done;

  // Access completes at the edge where waitrequest is low
  assign done = !c_reg.wreq && (avs_read || avs_write);
  assign fifo_in_valid = done && avs_write && (avs_address == pclt_pkg::OFS_CMD);
  assign fifo_out_ready = (c_reg.sst == pclt_pkg::SND_IDLE);

  pclt_fifo #(
    .W(FW),
    .D(pclt_pkg::FIFO_D)
  ) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(avs_writedata[FW-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_comb begin
    logic efall;
    logic erise;
    logic rbit;
    logic [9:0] sig;
    erise = link.evt & ~c_reg.prev;
    efall = ~link.evt & c_reg.prev;
    rbit = 1'h0;
    sig = '0;
    c_next = c_reg;
    c_next.prev = link.evt;

    // --------------------------------------------------------------
    // Register access
    // --------------------------------------------------------------
    c_next.wreq = 1'h1;
    if (c_reg.wreq && (avs_read || avs_write)) begin
      // A full queue holds the command write off
      c_next.wreq = avs_write && avs_address == pclt_pkg::OFS_CMD && !fifo_in_ready;
      c_next.rdata = '0;
      if (avs_read) begin
        unique case (avs_address)
          pclt_pkg::OFS_STATUS: begin
            c_next.rdata = {16'h0, c_reg.sent, 4'h0, c_reg.tnew,
                            (c_reg.sst != pclt_pkg::SND_IDLE), !fifo_in_ready, !fifo_out_valid};
          end
          pclt_pkg::OFS_TELEM: begin
            c_next.rdata = {23'h0, c_reg.tnew, c_reg.tele};
          end
          pclt_pkg::OFS_CTRL: begin
            c_next.rdata = {31'h0, c_reg.strap};
          end
          default: begin
            c_next.rdata = '0;
          end
        endcase
      end
    end
    if (done && avs_write && avs_address == pclt_pkg::OFS_CTRL) begin
      c_next.strap = avs_writedata[0];
    end
    if (done && avs_read && avs_address == pclt_pkg::OFS_TELEM) begin
      c_next.tnew = 1'h0;
    end

    // --------------------------------------------------------------
    // Frame sender
    // --------------------------------------------------------------
    unique case (c_reg.sst)
      pclt_pkg::SND_IDLE: begin
        c_next.oe = c_reg.strap;
        c_next.out = 1'h0;
        if (fifo_out_valid) begin
          sig[9:8] = fifo_out_data[pclt_pkg::CMD_MODE_BIT] ?
                     pclt_pkg::SIG_CURRENT : pclt_pkg::SIG_POWER;
          sig[7:0] = fifo_out_data[7:0];
          c_next.sbits = sig;
          c_next.sst = pclt_pkg::SND_PULSE;
          c_next.scnt = '0;
          c_next.sidx = 4'h0;
        end
      end
      pclt_pkg::SND_PULSE: begin
        c_next.scnt = c_reg.scnt + CW'(1);
        if (c_reg.scnt == CW'(PER_CYC - 1)) begin
          c_next.scnt = '0;
          c_next.sbits = {c_reg.sbits[8:0], 1'h0};
          c_next.sidx = c_reg.sidx + 4'h1;
          if (c_next.sidx == pclt_pkg::FRAME_PULSES) begin
            c_next.sst = pclt_pkg::SND_GAP;
            c_next.sent = c_reg.sent + 8'h1;
          end
        end
      end
      pclt_pkg::SND_GAP: begin
        c_next.scnt = c_reg.scnt + CW'(1);
        if (c_reg.scnt == CW'(GAP_CYC - 1)) begin
          c_next.sst = pclt_pkg::SND_IDLE;
          c_next.scnt = '0;
        end
      end
      default: begin
        c_next.sst = pclt_pkg::SND_IDLE;
      end
    endcase
    if (c_next.sst == pclt_pkg::SND_PULSE) begin
      c_next.oe = 1'h1;
      c_next.out = c_next.scnt < (c_next.sbits[9] ? CW'(ONE_CYC) : CW'(ZERO_CYC));
    end else if (c_next.sst == pclt_pkg::SND_GAP) begin
      c_next.oe = c_reg.strap;
      c_next.out = 1'h0;
    end

    // --------------------------------------------------------------
    // Telemetry receiver
    // --------------------------------------------------------------
    if (c_reg.rcnt != {CW{1'h1}}) begin
      c_next.rcnt = c_reg.rcnt + CW'(1);
    end
    if (erise) begin
      c_next.rcnt = '0;
    end
    if (efall) begin
      rbit = (c_reg.rcnt >= CW'(RX_ONE_CYC));
      if (c_reg.rcnt >= CW'(RX_START_CYC)) begin
        c_next.ridx = 4'h0;
      end else if (c_reg.ridx < pclt_pkg::DATA_BITS) begin
        c_next.rshift = {c_reg.rshift[6:0], rbit};
        c_next.ridx = c_reg.ridx + 4'h1;
        if (c_next.ridx == pclt_pkg::DATA_BITS) begin
          c_next.tele = {c_reg.rshift[6:0], rbit};
          c_next.tnew = 1'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      c_reg <= '{wreq: 1'h1, ridx: pclt_pkg::DATA_BITS, sst: pclt_pkg::SND_IDLE, default: '0};
    end else begin
      c_reg <= c_next;
    end
  end

  assign avs_readdata = c_reg.rdata;
  assign avs_waitrequest = c_reg.wreq;
  assign link.lim_oe = c_reg.oe;
  assign link.lim_out = c_reg.out;
endmodule : pclt_controller
`default_nettype wire

// >>> pclt_link_chk.sv
`timescale 1ns/1ns
`default_nettype none
module pclt_link_chk #(
  parameter int unsigned PER_CYC = pclt_pkg::PERIOD_CYC,
  parameter int unsigned ZERO_CYC = pclt_pkg::ZERO_CYC,
  parameter int unsigned ONE_CYC = pclt_pkg::ONE_CYC,
  parameter int unsigned START_CYC = pclt_pkg::START_CYC,
  parameter int unsigned GAP_CYC = pclt_pkg::GAP_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Link lines
  input wire logic lim_level,
  input wire logic evt
);
  // ----------
  // Run lengths and pulse counts
  // ----------
  logic [23:0] lh, ll, lp, eh, el, ep;
  logic [3:0] ln, en;
  logic lq, eq;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      {lh, lp, eh, el, ep} <= '0;
      ll <= '1;
      {ln, en, lq, eq} <= '0;
    end else begin
      lq <= lim_level;
      eq <= evt;
      lh <= lim_level ? lh + 24'h1 : '0;
      ll <= lim_level ? '0 : (&ll ? ll : ll + 24'h1);
      lp <= (lim_level & !lq) ? 24'h1 : lp + 24'h1;
      eh <= evt ? eh + 24'h1 : '0;
      el <= evt ? '0 : el + 24'h1;
      ep <= (evt & !eq) ? 24'h1 : ep + 24'h1;
      if (!lim_level & lq) ln <= (ln == 4'h9) ? '0 : ln + 4'h1;
      if (!evt & eq) en <= (en == 4'h8) ? '0 : en + 4'h1;
    end
  end

  // ----------
  // Wire checks
  // ----------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_lim_width: assert property (
    $fell(lim_level) |-> lh == ZERO_CYC || lh == ONE_CYC) else $error("limit pulse width");
  a_lim_period: assert property (
    $rose(lim_level) && ln != 0 |-> lp == PER_CYC) else $error("limit pulse period");
  a_lim_gap: assert property (
    $rose(lim_level) && ln == 0 |-> ll >= GAP_CYC) else $error("frame gap short");
  a_lim_in_frame: assert property (
    ln != 0 |-> ll <= PER_CYC - ZERO_CYC) else $error("frame cut short");
  a_evt_start: assert property (
    $fell(evt) && en == 0 |-> eh == START_CYC) else $error("start pulse width");
  a_evt_bit_width: assert property (
    $fell(evt) && en != 0 |-> eh == ZERO_CYC || eh == ONE_CYC) else $error("bit pulse width");
  a_evt_period: assert property (
    $rose(evt) && en != 0 |-> ep == PER_CYC) else $error("report pulse period");
  a_evt_in_report: assert property (
    en != 0 |-> el <= PER_CYC - ZERO_CYC) else $error("report cut short");
endmodule : pclt_link_chk
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ----------
  // Design hookup
  // ----------
  localparam int unsigned PER = 40;
  localparam int unsigned ONE = 30;
  localparam int unsigned GAP = 50;
  localparam int unsigned ZERO = 20;
  localparam int unsigned START = 36;
  localparam int unsigned TOL = 4;
  localparam int unsigned RXS = 33;
  localparam int unsigned RXO = 25;
  logic core_clk = 1'b0;
  logic reset, loop_active, report_go, limit_mode, frame_ok, frame_err, report_busy;
  logic frame_ok2, frame_err2, avs_read, avs_write, avs_waitrequest;
  logic [7:0] class_level, power_level, limit_level, limit_level2;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [16:0] rows [4] = '{17'h0A53C, 17'h15AC3, 17'h1FF00, 17'h000FF};
  logic [9:0] fb [3] = '{10'h081, 10'h181, 10'h181};
  int fw [3] = '{20, 12, 20};
  int n_errors = 0;
  int check_count = 0;
  pclt_link_if link ();
  pclt_link_if link2 ();
  always #4 core_clk = ~core_clk;

  pclt_device #(.PER_CYC(PER), .ZERO_CYC(ZERO), .ONE_CYC(ONE), .START_CYC(START),
    .GAP_CYC(GAP), .TOL_CYC(TOL)) pclt_device_inst (.core_clk, .reset, .link(link),
    .class_level, .loop_active, .limit_level, .limit_mode, .frame_ok, .frame_err,
    .power_level, .report_go, .report_busy);
  pclt_device #(.PER_CYC(PER), .ZERO_CYC(ZERO), .ONE_CYC(ONE), .START_CYC(START),
    .GAP_CYC(GAP), .TOL_CYC(TOL)) pclt_device_inst2 (.core_clk, .reset, .link(link2),
    .class_level, .loop_active(loop_active), .limit_level(limit_level2), .limit_mode(),
    .frame_ok(frame_ok2), .frame_err(frame_err2), .power_level(8'h00), .report_go(1'b0),
    .report_busy());
  pclt_controller #(.PER_CYC(PER), .ZERO_CYC(ZERO), .ONE_CYC(ONE), .GAP_CYC(GAP),
    .RX_START_CYC(RXS), .RX_ONE_CYC(RXO)) pclt_controller_inst (.core_clk, .reset,
    .link(link), .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest);
  pclt_link_chk #(.PER_CYC(PER), .ZERO_CYC(ZERO), .ONE_CYC(ONE), .START_CYC(START),
    .GAP_CYC(GAP)) pclt_link_chk_inst (.core_clk, .reset, .lim_level(link.lim_level),
    .evt(link.evt));

  // ----------
  // Tasks
  // ----------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task test_done;
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task timeout;
    n_errors++;
    test_done();
  endtask : timeout
  task rst;
    reset <= 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : rst
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    for (i = 0; i < 3000; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 3000) timeout();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av
  function automatic logic ev(input int k);
    case (k)
      0: return frame_ok;
      1: return !report_busy;
      2: return frame_ok2 | frame_err2;
      default: return limit_mode;
    endcase
  endfunction : ev
  task wait_ev(input int k);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge core_clk);
      if (ev(k) === 1'b1) break;
    end
    if (i == 3000) timeout();
  endtask : wait_ev
  // Drives a frame MSB first; zero pulses last wz cycles
  task send2(input logic [9:0] b, input int wz);
    int k, w;
    for (k = 9; k >= 0; k--) begin
      w = b[k] ? ONE : wz;
      link2.lim_oe <= 1'b1;
      link2.lim_out <= 1'b1;
      repeat (w) @(posedge core_clk);
      link2.lim_oe <= 1'b0;
      link2.lim_out <= 1'b0;
      repeat (k ? PER - w : 0) @(posedge core_clk);
    end
  endtask : send2

  // ----------
  // Main sequence
  // ----------
  initial begin
    int r;
    logic [1:0] st;
    {reset, loop_active, report_go, avs_read, avs_write} = 5'h10;
    {avs_address, avs_writedata, power_level, class_level} = {44'h0, 8'h42};
    {link2.lim_oe, link2.lim_out} = 2'h0;
    rst();
    chk(limit_level, class_level);
    chk(limit_mode, 1'b0);
    av(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    av(1'b1, 4'hC, 32'h1);
    repeat (GAP + 20) @(posedge core_clk);
    chk(limit_mode, 1'b1);
    av(1'b1, 4'hC, 32'h0);
    repeat (GAP + 20) @(posedge core_clk);
    chk(limit_mode, 1'b0);
    for (r = 0; r < 4; r++) begin
      power_level <= rows[r][7:0];
      report_go <= 1'b1;
      @(posedge core_clk);
      report_go <= 1'b0;
      av(1'b1, 4'h0, {23'h0, rows[r][16:8]});
      wait_ev(0);
      chk(limit_level, rows[r][15:8]);
      chk(limit_mode, rows[r][16]);
      wait_ev(1);
      av(1'b0, 4'h8, 32'h0);
      chk(rd[8:0], {1'b1, rows[r][7:0]});
    end
    loop_active <= 1'b1;
    av(1'b1, 4'h0, 32'h13C);
    wait_ev(0);
    chk(limit_level, 8'h3C);
    chk(limit_mode, 1'b0);
    loop_active <= 1'b0;
    wait_ev(3);
    chk(limit_mode, 1'b1);
    for (r = 0; r < 17; r++) av(1'b1, 4'h0, r);
    av(1'b0, 4'h4, 32'h0);
    chk(rd[1:0], 2'h2);
    av(1'b1, 4'h0, 32'h11);
    for (r = 0; r < 300; r++) begin
      repeat (100) @(posedge core_clk);
      av(1'b0, 4'h4, 32'h0);
      if (rd[2:0] === 3'h1) break;
    end
    if (r == 300) timeout();
    chk(limit_level, 8'h11);
    // two faulty frames, then one good frame, on the second link
    for (r = 0; r < 3; r++) begin
      repeat (GAP + 10) @(posedge core_clk);
      fork
        send2(fb[r], fw[r]);
        begin
          wait_ev(2);
          st = {frame_ok2, frame_err2};
        end
      join
      chk(st, (r == 2) ? 2'h2 : 2'h1);
      chk(limit_level2, (r == 2) ? 8'h81 : class_level);
    end
    rst();
    chk(limit_level, class_level);
    chk(limit_mode, 1'b0);
    test_done();
  end
endmodule : tb
`default_nettype wire
